// *** etd_pkg.sv ***
package etd_pkg;

  // register byte offsets
  localparam logic [7:0] ETD_OFS_CTRL = 8'h00;
  localparam logic [7:0] ETD_OFS_CMP = 8'h04;
  localparam logic [7:0] ETD_OFS_STATUS = 8'h08;
  localparam logic [7:0] ETD_OFS_MASK = 8'h0c;
  localparam logic [7:0] ETD_OFS_COUNT = 8'h10;

  // control, status and mask bit positions
  localparam int ETD_BIT_FF = 7;
  localparam int ETD_BIT_RUN = 3;
  localparam int ETD_BIT_MATCH = 0;

  // operating mode codes
  localparam logic [2:0] ETD_MODE_TIMER = 3'h0;
  localparam logic [2:0] ETD_MODE_DIVIDER = 3'h1;

  // clock select codes
  localparam logic [2:0] ETD_CK_SLOWEST = 3'h0;
  localparam logic [2:0] ETD_CK_DIV128 = 3'h1;
  localparam logic [2:0] ETD_CK_DIV32 = 3'h2;
  localparam logic [2:0] ETD_CK_DIV8 = 3'h3;
  localparam logic [2:0] ETD_CK_EVENT = 3'h7;

  // prescaler tap exponents and slow-clock divider
  localparam int ETD_PRE_WIDTH = 11;
  localparam int ETD_TAP_EXP0 = 11;
  localparam int ETD_TAP_EXP1 = 7;
  localparam int ETD_TAP_EXP2 = 5;
  localparam int ETD_TAP_EXP3 = 3;
  localparam int ETD_SLOW_EXP = 3;
  localparam int ETD_NUM_TAPS = 4;

  // reset values
  localparam logic [7:0] ETD_CTRL_RST = 8'h00;
  localparam logic [7:0] ETD_CMP_RST = 8'hff;
  localparam logic ETD_PIN_RST = 1'b1;

  // control register layout
  typedef struct packed {
    logic output_flip_flop_init_bit;
    logic [2:0] clock_select_field;
    logic run_control_bit;
    logic [2:0] operating_mode_field;
  } etd_ctrl_t;

endpackage : etd_pkg

// *** etd_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none
module etd_prescaler
  import etd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic prescaler_tap_select,
  input wire logic slow_tick,
  output logic [ETD_NUM_TAPS-1:0] tick_vec
);
  localparam int EXPS [ETD_NUM_TAPS] = '{ETD_TAP_EXP0, ETD_TAP_EXP1, ETD_TAP_EXP2, ETD_TAP_EXP3};
  logic [ETD_PRE_WIDTH-1:0] div_reg;
  logic [ETD_SLOW_EXP-1:0] slow_reg;
  logic slow_wrap;

  // free-running fast-clock divider
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // slow clock over eight for the alternate slowest tap
  always_ff @(posedge clk) begin
    if (rst) begin
      slow_reg <= '0;
    end else if (slow_tick) begin
      slow_reg <= slow_reg + 1'b1;
    end
  end

  assign slow_wrap = slow_tick && (&slow_reg);

  // one pulse per tap period, when the low bits are all ones, or for the alternate slowest tap when the slow count wraps
  genvar i;
  generate
    for (i = 0; i < ETD_NUM_TAPS; i++) begin : g_tap
      if (i == 0) begin : g_slowest
        assign tick_vec[i] = prescaler_tap_select ? slow_wrap : (&div_reg[EXPS[i]-1:0]);
      end else begin : g_fast
        assign tick_vec[i] = &div_reg[EXPS[i]-1:0];
      end
    end
  endgenerate
endmodule : etd_prescaler
`default_nettype wire

// *** etd_edge_detect.sv ***
`timescale 1ns/100ps
`default_nettype none
module etd_edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic event_input_pin,
  output logic fall_pulse
);
  logic prev_reg;

  // pin is synchronous already, so one stage remembers the level
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= event_input_pin;
    end
  end

  // reset to high, so a pin low out of reset counts as a falling edge
  assign fall_pulse = prev_reg && !event_input_pin;
endmodule : etd_edge_detect
`default_nettype wire

// *** etd_timer_channel.sv ***
`timescale 1ns/100ps
`default_nettype none
module etd_timer_channel
  import etd_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic event_input_pin,
  input wire logic prescaler_tap_select,
  input wire logic slow_tick,
  output logic divider_output_pin,
  output logic match_interrupt_request,
  output logic irq
);
  import etd_pkg::*;

  etd_ctrl_t ctrl_reg;
  logic [CNT_WIDTH-1:0] compare_value_register;
  logic [CNT_WIDTH-1:0] cnt_reg;
  logic [CNT_WIDTH-1:0] cnt_inc;
  logic status_reg;
  logic status_next;
  logic mask_reg;
  logic mask_next;
  logic pin_reg;
  logic match_pulse_reg;
  logic irq_reg;
  logic hresp_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic [ETD_NUM_TAPS-1:0] tick_vec;
  logic ev_fall;
  logic tick_sel;
  logic mode_ok;
  logic step;
  logic match;
  logic ap_take;
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  logic ctrl_wr;
  logic cmp_wr;
  logic status_wr;
  logic mask_wr;

  // internal clock taps
  etd_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .prescaler_tap_select(prescaler_tap_select),
    .slow_tick(slow_tick),
    .tick_vec(tick_vec)
  );

  // falling edges of the event pin
  etd_edge_detect u_edge (
    .clk(clk),
    .rst(rst),
    .event_input_pin(event_input_pin),
    .fall_pulse(ev_fall)
  );

  // address phase is taken when the bus is ready and a real transfer is selected
  assign ap_take = hsel && htrans[1] && hready;

  // remember the data-phase target; only word transfers are expected
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_wr_reg <= ap_take && hwrite;
      dp_addr_reg <= ap_take ? haddr[7:0] : dp_addr_reg;
    end
  end

  // write strobes in the data phase; unmapped writes fall through
  assign ctrl_wr = dp_wr_reg && (dp_addr_reg == ETD_OFS_CTRL);
  assign cmp_wr = dp_wr_reg && (dp_addr_reg == ETD_OFS_CMP);
  assign status_wr = dp_wr_reg && (dp_addr_reg == ETD_OFS_STATUS);
  assign mask_wr = dp_wr_reg && (dp_addr_reg == ETD_OFS_MASK);

  // zero-wait slave, always okay
  always_ff @(posedge clk) begin
    if (rst) begin
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  // read data decoded in the address phase so it stands in the data phase
  // limitation: a read right behind a write to the same word sees the old value
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      case (haddr[7:0])
        ETD_OFS_CTRL: hrdata_reg <= {24'h00_0000, ctrl_reg};
        ETD_OFS_CMP: hrdata_reg <= {{(32-CNT_WIDTH){1'b0}}, compare_value_register};
        ETD_OFS_STATUS: hrdata_reg <= {31'h0000_0000, status_reg};
        ETD_OFS_MASK: hrdata_reg <= {31'h0000_0000, mask_reg};
        ETD_OFS_COUNT: hrdata_reg <= {{(32-CNT_WIDTH){1'b0}}, cnt_reg};
        default: hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // control register; run bit and fields take effect at once
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= ETD_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= hwdata[7:0];
    end
  end

  // compare value drives the comparator directly, no shadow copy
  always_ff @(posedge clk) begin
    if (rst) begin
      compare_value_register <= ETD_CMP_RST;
    end else if (cmp_wr) begin
      compare_value_register <= hwdata[CNT_WIDTH-1:0];
    end
  end

  // only timer/event and divider codes count; pwm, cascade and reserved codes idle
  assign mode_ok = (ctrl_reg.operating_mode_field == ETD_MODE_TIMER)
    || (ctrl_reg.operating_mode_field == ETD_MODE_DIVIDER);

  // source tick: four internal taps, or event edges in timer/event mode only
  always_comb begin
    tick_sel = 1'b0;
    case (ctrl_reg.clock_select_field)
      ETD_CK_SLOWEST: tick_sel = tick_vec[0];
      ETD_CK_DIV128: tick_sel = tick_vec[1];
      ETD_CK_DIV32: tick_sel = tick_vec[2];
      ETD_CK_DIV8: tick_sel = tick_vec[3];
      ETD_CK_EVENT: tick_sel = ev_fall && (ctrl_reg.operating_mode_field == ETD_MODE_TIMER);
      default: tick_sel = 1'b0;
    endcase
  end

  assign step = ctrl_reg.run_control_bit && mode_ok && tick_sel;
  assign cnt_inc = cnt_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
  // match on the value the counter is about to reach
  assign match = step && (cnt_inc == compare_value_register);

  // up-counter; a stopped counter sits at zero so each start begins fresh
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!ctrl_reg.run_control_bit) begin
      cnt_reg <= '0;
    end else if (match) begin
      cnt_reg <= '0;
    end else if (step) begin
      cnt_reg <= cnt_inc;
    end
  end

  // pin flop holds the inverse of the output flip-flop, so the pin needs no gate
  // a write at the stop keeps the level; only writes made while stopped load it
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_reg <= ETD_PIN_RST;
    end else if (match && (ctrl_reg.operating_mode_field == ETD_MODE_DIVIDER)) begin
      pin_reg <= !pin_reg;
    end else if (ctrl_wr && !ctrl_reg.run_control_bit) begin
      pin_reg <= !hwdata[ETD_BIT_FF];
    end
  end

  // sticky match flag, write one to clear, a new match wins over the clear
  assign status_next = match || (status_reg && !(status_wr && hwdata[ETD_BIT_MATCH]));
  assign mask_next = mask_wr ? hwdata[ETD_BIT_MATCH] : mask_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  // interrupt level from next values so it tracks status with no extra lag
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
      match_pulse_reg <= 1'b0;
    end else begin
      irq_reg <= status_next && mask_next;
      match_pulse_reg <= match;
    end
  end

  assign hreadyout = hready_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign divider_output_pin = pin_reg;
  assign match_interrupt_request = match_pulse_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // stopped counter reads zero one edge later
  AST_STOP_CLEARS: assert property (!ctrl_reg.run_control_bit |=> (cnt_reg == '0))
    else $error("counter not cleared while stopped");

  // a match clears the counter and flags the event
  AST_MATCH_CLEARS: assert property (match |=> (cnt_reg == '0) && status_reg && match_interrupt_request)
    else $error("match did not clear counter or flag event");

  // a step that does not match advances by exactly one
  AST_STEP_INC: assert property (step && !match && ctrl_reg.run_control_bit
    |=> (cnt_reg == $past(cnt_inc)))
    else $error("counter did not advance by one");

  // in event selection only falling edges move the counter
  AST_EVENT_ONLY: assert property ((ctrl_reg.run_control_bit && ctrl_reg.clock_select_field == ETD_CK_EVENT
    && !ev_fall) |=> $stable(cnt_reg))
    else $error("counter moved without an event edge");

  // divider match flips the pin
  AST_PDO_TOGGLE: assert property ((match && ctrl_reg.operating_mode_field == ETD_MODE_DIVIDER)
    |=> (divider_output_pin != $past(divider_output_pin)))
    else $error("divider pin did not toggle on match");

  // timer mode matches leave the pin alone
  AST_TIMER_PIN_STILL: assert property ((match && ctrl_reg.operating_mode_field == ETD_MODE_TIMER)
    |=> $stable(divider_output_pin))
    else $error("pin moved on a timer match");

  // the stopping write keeps the pin level
  // a match on the very stopping edge is the last count and may still toggle
  AST_STOP_HOLD: assert property ((ctrl_wr && ctrl_reg.run_control_bit && !hwdata[ETD_BIT_RUN] && !match)
    |=> $stable(divider_output_pin))
    else $error("pin changed on the stopping write");

  // a write while stopped loads the inverse of the flip-flop bit onto the pin
  AST_PIN_LOAD: assert property ((ctrl_wr && !ctrl_reg.run_control_bit)
    |=> (divider_output_pin == !$past(hwdata[ETD_BIT_FF])))
    else $error("pin not loaded from flip-flop bit");

  // a new compare value is used at the next comparison
  AST_CMP_IMMEDIATE: assert property (cmp_wr ##1 (step && cnt_inc == $past(hwdata[CNT_WIDTH-1:0])) |-> match)
    else $error("new compare value not used at once");

  // set wins over a simultaneous clear
  AST_SET_WINS: assert property ((match && status_wr && hwdata[ETD_BIT_MATCH]) |=> status_reg)
    else $error("match lost under clear");

  // interrupt line follows masked status
  AST_IRQ_LEVEL: assert property (##1 (irq == (status_reg && mask_reg)))
    else $error("interrupt level does not follow masked status");

  // codes other than timer and divider never count
  AST_MODE_IDLE: assert property (!mode_ok |-> !step ##1 (cnt_reg == '0 || $stable(cnt_reg)))
    else $error("counter moved in an idle mode");

endmodule : etd_timer_channel
`default_nettype wire

// *** etd_event_source.sv ***
`timescale 1ns/100ps
`default_nettype none
// far side: event pulse source (pulled-up pin, idle high) and divider load
module etd_event_source (
  input wire logic clk,
  input wire logic divider_output_pin,
  output logic event_input_pin
);
  int load_edges = 0;
  initial event_input_pin = 1'b1;
  // each phase held half clocks; callers keep half at two machine cycles or more
  task automatic burst(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge clk);
      event_input_pin <= 1'b0;
      repeat (half) @(posedge clk);
      event_input_pin <= 1'b1;
    end
  endtask : burst
  // load counts level changes of the divided wave
  always @(divider_output_pin) load_edges++;
endmodule : etd_event_source
`default_nettype wire

// *** tb_eight_bit_timer_event_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_eight_bit_timer_event_divider;
  import etd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, pin, mirq, irq, ev;
  int error_cnt = 0;
  int num_checks = 0;
  int c, e0;

  always #2 clk = ~clk;

  // hready is the lone slave's own ready
  etd_timer_channel #(.CNT_WIDTH(8)) dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_input_pin(ev),
    .prescaler_tap_select(1'b0), .slow_tick(1'b0), .divider_output_pin(pin),
    .match_interrupt_request(mirq), .irq(irq));
  etd_event_source src_u (.clk(clk), .divider_output_pin(pin), .event_input_pin(ev));

  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check32

  // single AHB transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    check32(name, exp, rd);
  endtask : rchk

  // bounded wait for the match pulse, counting edges
  task automatic wait_match(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (mirq !== 1'b1 && n < 3000);
    if (n >= 3000) check32("match_timeout", 32'h1, 32'h0);
  endtask : wait_match

  task automatic t_reset;
    rchk("ctrl_rst", ETD_OFS_CTRL, 32'h0);
    rchk("cmp_rst", ETD_OFS_CMP, {24'h0, ETD_CMP_RST});
    rchk("count_rst", ETD_OFS_COUNT, 32'h0);
    check32("pin_rst", 32'h1, {31'h0, pin});
    check32("hresp_okay", 32'h0, {31'h0, hresp});
    wr(8'h20, 32'hff);
    rchk("unmapped", 8'h20, 32'h0);
  endtask : t_reset

  // timer on clk/8, compare 3; interrupt path
  task automatic t_timer;
    wr(ETD_OFS_CMP, 32'h3);
    wr(ETD_OFS_CTRL, 32'h30);
    wr(ETD_OFS_CTRL, 32'h38);
    wait_match(c);
    wait_match(c);
    check32("timer_period", 32'd24, c);
    check32("timer_pin", 32'h1, {31'h0, pin});
    check32("irq_masked", 32'h0, {31'h0, irq});
    rchk("status_set", ETD_OFS_STATUS, 32'h1);
    wr(ETD_OFS_STATUS, 32'h1);
    rchk("status_clr", ETD_OFS_STATUS, 32'h0);
    wr(ETD_OFS_MASK, 32'h1);
    wait_match(c);
    check32("irq_on", 32'h1, {31'h0, irq});
    wr(ETD_OFS_STATUS, 32'h1);
    @(posedge clk);
    check32("irq_off", 32'h0, {31'h0, irq});
    wr(ETD_OFS_CTRL, 32'h30);
    repeat (40) @(posedge clk);
    rchk("count_stop", ETD_OFS_COUNT, 32'h0);
  endtask : t_timer

  // divider on clk/8, compare 2: toggle every 16 clocks
  task automatic t_divider;
    wr(ETD_OFS_CMP, 32'h2);
    // no port latch here: the load sees the pin directly
    wr(ETD_OFS_CTRL, 32'h31);
    wr(ETD_OFS_CTRL, 32'h39);
    e0 = src_u.load_edges;
    wait_match(c);
    check32("div_pin0", 32'h0, {31'h0, pin});
    wait_match(c);
    check32("div_period", 32'd16, c);
    check32("div_pin1", 32'h1, {31'h0, pin});
    check32("load_edges", 32'd2, src_u.load_edges - e0);
    wait_match(c);
    wr(ETD_OFS_CTRL, 32'h31);
    repeat (40) @(posedge clk);
    check32("div_hold", 32'h0, {31'h0, pin});
    wr(ETD_OFS_CTRL, 32'h31);
    @(posedge clk);
    check32("div_high", 32'h1, {31'h0, pin});
    wr(ETD_OFS_CTRL, 32'hb1);
    @(posedge clk);
    check32("div_load", 32'h0, {31'h0, pin});
    wr(ETD_OFS_CTRL, 32'h31);
  endtask : t_divider

  // event counting; compare changed only while stopped
  task automatic t_event;
    wr(ETD_OFS_CMP, 32'h5);
    wr(ETD_OFS_CTRL, 32'h70);
    wr(ETD_OFS_CTRL, 32'h78);
    src_u.burst(2, 4);
    repeat (4) @(posedge clk);
    rchk("ev_count", ETD_OFS_COUNT, 32'h2);
    wr(ETD_OFS_CTRL, 32'h70);
    wr(ETD_OFS_CMP, 32'h3);
    wr(ETD_OFS_CTRL, 32'h78);
    fork
      src_u.burst(3, 4);
      wait_match(c);
    join
    check32("ev_fast", 32'h1, {31'h0, c < 26});
    rchk("ev_clear", ETD_OFS_COUNT, 32'h0);
    wr(ETD_OFS_CTRL, 32'h70);
  endtask : t_event

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_timer();
    t_divider();
    t_event();
    tally_and_finish();
  end

  // a hung handshake ends here; a missing match times out in wait_match
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_eight_bit_timer_event_divider
`default_nettype wire
